// file: logic/lds_consts.vh
/*
  constants for the led display digit scanner: clock divider, slot length,
  digit count, data code meanings.
  assumes a 25 MHz system clock.
*/
`ifndef LDS_CONSTS_VH
`define LDS_CONSTS_VH

`define LDS_CLK_HZ 25000000
`define LDS_PHASE_HZ 170000
// cycles per full two-phase period, rounded down so the rate never falls short
`define LDS_PERIOD_CYC (`LDS_CLK_HZ / `LDS_PHASE_HZ)
`define LDS_QUARTER_CYC (`LDS_PERIOD_CYC / 4)
`define LDS_SLOT_BITS 4
`define LDS_NUM_DIGITS 15
`define LDS_SEG_OFF 7'h00
`define LDS_CODE_BLANK 4'hF

`endif

// file: logic/lds_digit_scanner.v
/*
  led display digit scanner: two-phase clock generator, segment decoder,
  shift-clock generator and digit position counter.
  the two-flop synchroniser is a small module at the end of the file.
  assumes data and start come from logic outside this clock domain and are
  stable for each bit-time of the generated clock.
*/
// How it works
// RL1: make non-overlapping two-phase clock at 170 kHz
// RL2: demultiplex five data lines into segment anodes
// RL3: one segment set shared by every digit
// RL4: enable exactly one digit position at once; the code enables none after the last digit shifts out
// RL5: one shift pulse after four bit-times
// RL6: shift pulse advances digit to the right
// RL7: decimal point gives two consecutive shift pulses
// RL8: point arrives with the preceding digit's data; the code latches it with its own digit's data
// RL9: blank digit keeps timing, drives no anodes
// RL10: start resets digit counter to position one
// RL11: busy lamp switched by the I/O processor
// RL12: fixed table decodes codes, blank means off
`timescale 1ns/1ps
`include "lds_consts.vh"

module lds_digit_scanner #(
  parameter NUM_DIGITS = `LDS_NUM_DIGITS,
  parameter SLOT_BITS = `LDS_SLOT_BITS
) (
  input wire clock,
  input wire rst,
  input wire clkEn,
  input wire [4:0] digitData,
  input wire startWord,
  output reg phase1_ff,
  output reg phase2_ff,
  output reg [6:0] segAnode_ff,
  output reg decPoint_ff,
  output reg shiftClk_ff,
  output reg [NUM_DIGITS-1:0] digitEn_ff
);

////////////////////////////////////////////////////////////////////////
// pin synchronisers; the start edge is taken only after both flops
wire [4:0] dataSync;
wire startSync;
reg startPrev_ff;

lds_sync2 #(
  .WIDTH(5)
) u_dataSync (
  .clock(clock),
  .rst(rst),
  .clkEn(clkEn),
  .pinIn(digitData),
  .syncOut_ff(dataSync)
);

lds_sync2 #(
  .WIDTH(1)
) u_startSync (
  .clock(clock),
  .rst(rst),
  .clkEn(clkEn),
  .pinIn(startWord),
  .syncOut_ff(startSync)
);

always @(posedge clock or posedge rst) begin
  if (rst) begin
    startPrev_ff <= 1'b0;
  end else if (clkEn) begin
    startPrev_ff <= startSync;
  end
end

wire startRise = startSync & ~startPrev_ff;

////////////////////////////////////////////////////////////////////////
// two-phase clock: four quarters, phase1 in q0, phase2 in q2, gaps between
// quarters round down, so the rate lands slightly above nominal, never below
localparam integer QUARTER_I = `LDS_QUARTER_CYC;
localparam [15:0] QUARTER = QUARTER_I[15:0];
localparam [3:0] Q_PH1 = 4'h1;
localparam [3:0] Q_GAP1 = 4'h2;
localparam [3:0] Q_PH2 = 4'h4;
localparam [3:0] Q_GAP2 = 4'h8;
reg [15:0] divCnt_ff;
reg [3:0] quarter_ff;
reg [3:0] nxt_quarter;
wire quarterEnd = (divCnt_ff == QUARTER - 16'h0001);
wire bitEnd = quarterEnd & (quarter_ff == Q_GAP2);

always @* begin
  case (quarter_ff)
    Q_PH1: nxt_quarter = Q_GAP1;
    Q_GAP1: nxt_quarter = Q_PH2;
    Q_PH2: nxt_quarter = Q_GAP2;
    Q_GAP2: nxt_quarter = Q_PH1;
    // an upset code restarts at the first quarter rather than locking up
    default: nxt_quarter = Q_PH1;
  endcase
end

always @(posedge clock or posedge rst) begin
  if (rst) begin
    divCnt_ff <= 16'h0000;
    quarter_ff <= Q_PH1;
    phase1_ff <= 1'b0;
    phase2_ff <= 1'b0;
  end else if (clkEn) begin
    divCnt_ff <= quarterEnd ? 16'h0000 : divCnt_ff + 16'h0001;
    if (quarterEnd) begin
      quarter_ff <= nxt_quarter;
      phase1_ff <= (nxt_quarter == Q_PH1); // RL1
      phase2_ff <= (nxt_quarter == Q_PH2); // RL1
    end
  end
end

////////////////////////////////////////////////////////////////////////
// segment decode: data[3:0] digit code, data[4] decimal point
function [6:0] segDecode;
  input [3:0] code;
  begin
    case (code) // RL12
      4'h0: segDecode = 7'h3F;
      4'h1: segDecode = 7'h06;
      4'h2: segDecode = 7'h5B;
      4'h3: segDecode = 7'h4F;
      4'h4: segDecode = 7'h66;
      4'h5: segDecode = 7'h6D;
      4'h6: segDecode = 7'h7D;
      4'h7: segDecode = 7'h07;
      4'h8: segDecode = 7'h7F;
      4'h9: segDecode = 7'h6F;
      4'hA: segDecode = 7'h40;
      default: segDecode = `LDS_SEG_OFF; // RL9
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////////////
// slot timing and shift pulses
localparam integer SLOT_LAST_I = SLOT_BITS - 1;
localparam [2:0] SLOT_LAST = SLOT_LAST_I[2:0];
localparam [NUM_DIGITS-1:0] DIGIT_FIRST = {{(NUM_DIGITS-1){1'b0}}, 1'b1};
reg [2:0] bitCnt_ff;
reg pointPending_ff;
reg [NUM_DIGITS-1:0] nxt_digitEn;
reg nxt_shift;

always @* begin
  nxt_shift = 1'b0;
  nxt_digitEn = digitEn_ff;
  // start wins over a pulse that falls in the same cycle
  if (startRise) begin
    nxt_digitEn = DIGIT_FIRST; // RL10
  end else if (bitEnd && bitCnt_ff == SLOT_LAST) begin
    nxt_shift = 1'b1; // RL5
  // the extra pulse sits one bit early so both fit inside the slot
  end else if (bitEnd && pointPending_ff && bitCnt_ff == SLOT_LAST - 3'h1) begin
    nxt_shift = 1'b1; // RL7
  end
  if (shiftClk_ff && !startRise) begin
    // walks right, one hot; falls off the end until the next start
    nxt_digitEn = {digitEn_ff[NUM_DIGITS-2:0], 1'b0}; // RL6 RL4
  end
end

always @(posedge clock or posedge rst) begin
  if (rst) begin
    bitCnt_ff <= 3'h0;
    pointPending_ff <= 1'b0;
    segAnode_ff <= `LDS_SEG_OFF;
    decPoint_ff <= 1'b0;
    shiftClk_ff <= 1'b0;
    digitEn_ff <= DIGIT_FIRST;
  end else if (clkEn) begin
    shiftClk_ff <= nxt_shift;
    digitEn_ff <= nxt_digitEn;
    if (startRise) begin
      bitCnt_ff <= 3'h0;
      pointPending_ff <= 1'b0;
    end else if (bitEnd) begin
      bitCnt_ff <= (bitCnt_ff == SLOT_LAST) ? 3'h0 : bitCnt_ff + 3'h1;
      if (bitCnt_ff == 3'h0) begin
        // point is latched with its digit so the extra pulse lands in-slot
        // limitation: the first bit-time of a slot still shows the previous digit
        pointPending_ff <= dataSync[4]; // RL8
        segAnode_ff <= segDecode(dataSync[3:0]); // RL2 RL3
        decPoint_ff <= dataSync[4];
      end
    end
  end
end

endmodule // lds_digit_scanner

////////////////////////////////////////////////////////////////////////
// two-flop synchroniser for a group of pin inputs
module lds_sync2 #(
  parameter WIDTH = 1
) (
  input wire clock,
  input wire rst,
  input wire clkEn,
  input wire [WIDTH-1:0] pinIn,
  output reg [WIDTH-1:0] syncOut_ff
);

reg [WIDTH-1:0] meta_ff;

// resets to the idle pin level so no false start edge follows reset
always @(posedge clock or posedge rst) begin
  if (rst) begin
    meta_ff <= {WIDTH{1'b0}};
    syncOut_ff <= {WIDTH{1'b0}};
  end else if (clkEn) begin
    meta_ff <= pinIn;
    syncOut_ff <= meta_ff;
  end
end

endmodule // lds_sync2

// file: tb/lds_chk_assertions.sv
/* port checker for the scanner; bound to every instance */
`timescale 1ns/1ps
module lds_chk (
  input wire clock,
  input wire rst,
  input wire clkEn,
  input wire startWord,
  input wire phase1_ff,
  input wire phase2_ff,
  input wire shiftClk_ff,
  input wire [14:0] digitEn_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst || !clkEn);
  property p_noOvl; !(phase1_ff && phase2_ff); endproperty
  a_noOvl: assert property (p_noOvl) else $error("phases overlap");
  property p_hold; $rose(phase1_ff) |-> phase1_ff[*8]; endproperty
  a_hold: assert property (p_hold) else $error("phase one too short");
  property p_gap; $rose(phase1_ff) |-> ##72 $rose(phase2_ff); endproperty
  a_gap: assert property (p_gap) else $error("phase two late");
  property p_per; $rose(phase1_ff) |-> ##144 $rose(phase1_ff); endproperty
  a_per: assert property (p_per) else $error("bit-time wrong");
  property p_one; $onehot0(digitEn_ff); endproperty
  a_one: assert property (p_one) else $error("two digits on");
  property p_pulse; shiftClk_ff |=> !shiftClk_ff[*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("shift pulse long");
  property p_adv;
    shiftClk_ff && !($past(startWord, 2) && !$past(startWord, 3)) |=> digitEn_ff == {$past(digitEn_ff[13:0]), 1'b0};
  endproperty
  a_adv: assert property (p_adv) else $error("no advance");
  property p_start; $rose(startWord) |-> ##3 digitEn_ff == 15'h0001; endproperty
  a_start: assert property (p_start) else $error("no restart");
endmodule // lds_chk
////////////////////////////////////////
bind lds_digit_scanner lds_chk u_chk (.*);

// file: tb/lds_ar_model.sv
/* register-side model: start marker held through the first of 15 slots of data */
`timescale 1ns/1ps
module lds_ar_model (
  input wire clock,
  output reg [4:0] digitData,
  output reg startWord
);
  integer i;
  reg busyLamp;
  initial begin
    digitData = 5'h0F;
    startWord = 1'b0;
    busyLamp = 1'b0;
  end
  task word(input [74:0] w);
    begin
      @(negedge clock);
      busyLamp = 1'b1;
      startWord = 1'b1;
      for (i = 0; i < 15; i = i + 1) begin
        digitData = w[5*i+:5];
        repeat (576) @(negedge clock);
        startWord = 1'b0;
      end
      busyLamp = 1'b0;
    end
  endtask
endmodule // lds_ar_model

// file: tb/tb_led_display_digit_scanner.sv
/* self-checking bench; partner sends words, bench follows shift pulses; checker is bound */
`timescale 1ns/1ps
module tb_led_display_digit_scanner;
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg clkEn = 1'b1;
  reg [1:0] phHeld;
  wire [4:0] digitData;
  wire startWord, phase1, phase2, decPoint, shiftClk;
  wire [6:0] seg;
  wire [14:0] digitEn;
  integer num_errors = 0, tests_run = 0, k, j, n, p = 0;
  reg [74:0] w;
  // {point, code, segments}; codes B, C, E, F blank
  reg [11:0] r [0:14] = '{12'h03F, 12'h086, 12'h95B, 12'h1CF, 12'h266, 12'h2ED, 12'h37D, 12'h387,
    12'h47F, 12'h4EF, 12'h540, 12'h580, 12'h600, 12'h700, 12'h780};
  always #20 clock = ~clock;
  lds_digit_scanner u_dut (.clock(clock), .rst(rst), .clkEn(clkEn), .digitData(digitData),
    .startWord(startWord), .phase1_ff(phase1), .phase2_ff(phase2), .segAnode_ff(seg),
    .decPoint_ff(decPoint), .shiftClk_ff(shiftClk), .digitEn_ff(digitEn));
  lds_ar_model u_ar (.clock(clock), .digitData(digitData), .startWord(startWord));
  task chk(input [14:0] got, input [14:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: %h vs %h", $time, got, exp);
      end
    end
  endtask
  task stop_test;
    begin
      $display("errors %0d of %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (16) @(negedge clock);
    rst = 1'b0;
    chk(digitEn, 15'h0001);
    chk(seg, 15'h0000);
    chk({phase1, phase2}, 15'h0000);
    for (k = 0; k < 15; k = k + 1) w[5*k+:5] = r[k][11:7];
    fork
      u_ar.word(w);
      for (k = 0; k < 15; k = k + 1)
        for (j = 0; j <= r[k][11]; j = j + 1) begin
          n = 0;
          do begin @(negedge clock); n = n + 1; end while (shiftClk !== 1'b1 && n < 700);
          if (n >= 700) begin num_errors = num_errors + 1; stop_test; end
          chk(digitEn, 15'h0001 << p);
          chk(seg, r[k][6:0]);
          chk(decPoint, r[k][11]);
          p = p + 1;
        end
    join
    // point pushed the last digit past position 15
    @(negedge clock);
    chk(digitEn, 15'h0000);
    // second word: restart, freeze and reset while the scan runs
    fork
      u_ar.word(w);
      begin
        repeat (4) @(negedge clock);
        chk(digitEn, 15'h0001);
        clkEn = 1'b0;
        phHeld = {phase1, phase2};
        repeat (40) @(negedge clock);
        // a quarter is 36 cycles, so a running clock would have moved a phase
        chk({phase1, phase2}, phHeld);
        chk(digitEn, 15'h0001);
        clkEn = 1'b1;
        repeat (200) @(negedge clock);
        rst = 1'b1;
        @(negedge clock);
        chk(digitEn, 15'h0001);
        chk({seg, decPoint, shiftClk, phase1, phase2}, 15'h0000);
        rst = 1'b0;
        @(negedge clock);
        chk({shiftClk, phase1, phase2}, 15'h0000);
        @(negedge clock);
        chk(digitEn, 15'h0001);
      end
    join
    stop_test;
  end
endmodule // tb_led_display_digit_scanner
